/* rtl/asr_monitor.sv */
// monitor converter sequencer with result read-out over the configuration
// port, a debug access port and an apb register slave
// assumes analog levels arrive as slow 10-bit codes from another domain and
// that the configuration and debug ports run on clk
`timescale 1ns/1ps

module asr_monitor
    import asr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        fabric_configured,
    input  wire logic        port_clock_present,
    input  wire logic [9:0]  temp_code,
    input  wire logic [9:0]  int_supply_code,
    input  wire logic [9:0]  aux_supply_code,
    input  wire logic [9:0]  dedicated_input_positive,
    input  wire logic [9:0]  dedicated_input_negative,
    input  wire logic        port_enable,
    input  wire logic        port_write_enable,
    input  wire logic [6:0]  port_address,
    input  wire logic [15:0] port_write_data,
    output logic [15:0]      port_read_data,
    output logic             port_data_ready,
    input  wire logic        jtag_enable,
    input  wire logic        jtag_write_enable,
    input  wire logic [6:0]  jtag_address,
    input  wire logic [15:0] jtag_write_data,
    output logic [15:0]      jtag_read_data,
    output logic             jtag_data_ready,
    output logic             busy,
    output logic             end_of_sequence,
    output logic [4:0]       channel,
    output logic             alarm_aux,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    // ****************************************
    // declarations
    // ****************************************
    logic [1:0]            cfg_sync;
    logic [1:0]            pclk_sync;
    logic [9:0]            code_meta [5];
    logic [9:0]            code_sync [5];
    logic                  configured;
    logic                  port_live;
    asr_seq_state_t        state;
    logic [1:0]            slot;
    logic [1:0]            cal_count;
    logic [3:0]            seq_select;
    logic [15:0]           upper_limit;
    logic [15:0]           lower_limit;
    logic [15:0]           results [NUM_SLOTS];
    logic [15:0]           cal_result;
    logic [1:0]            irq_status;
    logic [1:0]            irq_mask;
    logic                  alarm_prev;
    logic [2:0]            port_count;
    logic [6:0]            port_addr_held;
    logic                  conv_start;
    logic [CONV_CNT_W-1:0] conv_cycles;
    logic [9:0]            conv_code;
    logic                  conv_busy;
    logic                  conv_done;
    logic [15:0]           conv_result;
    logic [3:0]            active_sel;
    logic [2:0]            first_pick;
    logic [2:0]            next_pick;
    logic                  port_take;
    logic                  apb_access;
    logic                  apb_write;
    logic                  apb_hit;
    logic [31:0]           apb_word;
    // ****************************************
    // decode helpers
    // ****************************************
    // first enabled slot at or above from; bit 2 marks a find
    function automatic logic [2:0] pick_slot(input logic [3:0] sel, input logic [2:0] from);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (sel[i] && (3'(i) >= from)) r = {1'b1, 2'(i)};
        end
        return r;
    endfunction
    function automatic logic [4:0] slot_channel(input logic [1:0] s);
        logic [4:0] c;
        c = CH_TEMP;
        unique case (s)
            2'h0: c = CH_TEMP;
            2'h1: c = CH_INT;
            2'h2: c = CH_AUX;
            2'h3: c = CH_DED;
        endcase
        return c;
    endfunction
    // shared by the configuration port and the debug port
    function automatic logic [15:0] reg_read(input logic [6:0] a);
        logic [15:0] d;
        d = 16'h0000;
        if (a == {2'h0, CH_CAL}) d = cal_result;
        else if (a[6:2] == 5'h00) d = results[a[1:0]];
        else if (a == PA_SEQ) d = {12'h000, seq_select};
        else if (a == PA_UPPER) d = upper_limit;
        else if (a == PA_LOWER) d = lower_limit;
        return d;
    endfunction
    // ****************************************
    // input synchronisers
    // ****************************************
    // codes are slow levels; a two-flop stage per bit is enough here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_sync  <= 2'h0;
            pclk_sync <= 2'h0;
            code_meta <= '{default: '0};
            code_sync <= '{default: '0};
        end else begin
            cfg_sync     <= {cfg_sync[0], fabric_configured};
            pclk_sync    <= {pclk_sync[0], port_clock_present};
            code_meta[0] <= temp_code;
            code_meta[1] <= int_supply_code;
            code_meta[2] <= aux_supply_code;
            code_meta[3] <= dedicated_input_positive;
            code_meta[4] <= dedicated_input_negative;
            code_sync    <= code_meta;
        end
    end
    assign configured = cfg_sync[1];
    assign port_live  = pclk_sync[1] && configured;

    // ****************************************
    // sequencer
    // ****************************************
    // unconfigured device keeps on-chip sensors; external only on request
    assign active_sel = configured ? seq_select : {seq_select[3], ONCHIP_SEL[2:0]};
    assign first_pick = pick_slot(active_sel, 3'h0);
    assign next_pick  = pick_slot(active_sel, {1'b0, slot} + 3'h1);
    assign conv_start = (state == ST_CAL_START) || (state == ST_CH_START);
    assign conv_cycles = (state == ST_CAL_START) ? CONV_CNT_W'(CAL_STEP_CYCLES)
                                                 : CONV_CNT_W'(CONV_CYCLES);

    // dedicated input is differential; negative differences clip to zero
    always_comb begin
        conv_code = CAL_CODE;
        if (state == ST_CH_START) begin
            unique case (slot)
                2'h0: conv_code = code_sync[0];
                2'h1: conv_code = code_sync[1];
                2'h2: conv_code = code_sync[2];
                2'h3: conv_code = (code_sync[3] >= code_sync[4]) ?
                                  code_sync[3] - code_sync[4] : 10'h000;
            endcase
        end
    end

    // the sequencer never idles; conversion keeps going without a port clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_CAL_START;
            slot      <= 2'h0;
            cal_count <= 2'h0;
        end else begin
            unique case (state)
                ST_CAL_START: state <= ST_CAL_WAIT;
                ST_CAL_WAIT: begin
                    if (conv_done) begin
                        if (cal_count == 2'(CAL_STEPS - 1)) begin
                            cal_count <= 2'h0;
                            slot      <= first_pick[1:0];
                            state     <= first_pick[2] ? ST_CH_START : ST_EOS;
                        end else begin
                            cal_count <= cal_count + 2'h1;
                            state     <= ST_CAL_START;
                        end
                    end
                end
                ST_CH_START: state <= ST_CH_WAIT;
                ST_CH_WAIT: begin
                    if (conv_done) begin
                        slot  <= next_pick[1:0];
                        state <= next_pick[2] ? ST_CH_START : ST_EOS;
                    end
                end
                ST_EOS: state <= ST_CAL_START;
            endcase
        end
    end
    asr_converter u_conv (
        .clk         (clk),
        .reset_n     (reset_n),
        .start       (conv_start),
        .cycles      (conv_cycles),
        .sample_code (conv_code),
        .busy        (conv_busy),
        .done        (conv_done),
        .result      (conv_result)
    );
    assign busy = conv_busy;
    // ****************************************
    // results, channel, alarm, end of sequence
    // ****************************************
    // alarm lands on the busy-fall edge, end of sequence at least one later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            results         <= '{default: '0};
            cal_result      <= '0;
            channel         <= CH_TEMP;
            alarm_aux       <= 1'b0;
            end_of_sequence <= 1'b0;
        end else begin
            end_of_sequence <= (state == ST_EOS);
            if (conv_done && state == ST_CAL_WAIT) begin
                cal_result <= conv_result;
                channel    <= CH_CAL;
            end
            if (conv_done && state == ST_CH_WAIT) begin
                results[slot] <= conv_result;
                channel       <= slot_channel(slot);
                if (slot == 2'(SLOT_AUX)) begin
                    alarm_aux <= (conv_result > upper_limit) ||
                                 (conv_result < lower_limit);
                end
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    assign apb_access = psel && penable && pready;
    assign apb_write  = apb_access && pwrite;
    assign port_take  = port_enable && port_live && (port_count == 3'h0);
    // apb wins over the configuration port, which wins over debug
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seq_select  <= SEQ_RST;
            upper_limit <= UPPER_RST;
            lower_limit <= LOWER_RST;
        end else if (apb_write) begin
            if (paddr == OFS_SEQ) seq_select <= pwdata[3:0];
            if (paddr == OFS_UPPER) upper_limit <= pwdata[15:0];
            if (paddr == OFS_LOWER) lower_limit <= pwdata[15:0];
        end else if (port_take && port_write_enable) begin
            if (port_address == PA_SEQ) seq_select <= port_write_data[3:0];
            if (port_address == PA_UPPER) upper_limit <= port_write_data;
            if (port_address == PA_LOWER) lower_limit <= port_write_data;
        end else if (jtag_enable && jtag_write_enable) begin
            if (jtag_address == PA_SEQ) seq_select <= jtag_write_data[3:0];
            if (jtag_address == PA_UPPER) upper_limit <= jtag_write_data;
            if (jtag_address == PA_LOWER) lower_limit <= jtag_write_data;
        end
    end

    // ****************************************
    // configuration port read-out
    // ****************************************
    // one request in flight; enables during the wait are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_count      <= 3'h0;
            port_addr_held  <= 7'h00;
            port_read_data  <= 16'h0000;
            port_data_ready <= 1'b0;
        end else begin
            port_data_ready <= 1'b0;
            if (port_take) begin
                port_count     <= 3'(READ_LATENCY - 1);
                port_addr_held <= port_address;
            end else if (port_count != 3'h0) begin
                port_count <= port_count - 3'h1;
                if (port_count == 3'h1 && port_live) begin
                    port_read_data  <= reg_read(port_addr_held);
                    port_data_ready <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // debug port read-out
    // ****************************************
    // no dependence on configuration or on the port clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            jtag_read_data  <= 16'h0000;
            jtag_data_ready <= 1'b0;
        end else begin
            jtag_data_ready <= jtag_enable;
            if (jtag_enable) jtag_read_data <= reg_read(jtag_address);
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    // a new event in the clearing cycle survives the write of one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
            alarm_prev <= 1'b0;
        end else begin
            alarm_prev <= alarm_aux;
            if (apb_write && paddr == OFS_IRQ_MK) irq_mask <= pwdata[1:0];
            irq_status <= (irq_status & ~((apb_write && paddr == OFS_IRQ_ST) ?
                                          pwdata[1:0] : 2'h0))
                        | {alarm_aux && !alarm_prev, end_of_sequence};
        end
    end
    assign irq = |(irq_status & irq_mask);
    // ****************************************
    // apb slave
    // ****************************************
    always_comb begin
        apb_hit  = 1'b1;
        apb_word = 32'h0000_0000;
        unique case (paddr)
            OFS_SEQ:    apb_word = {28'h0000000, seq_select};
            OFS_UPPER:  apb_word = {16'h0000, upper_limit};
            OFS_LOWER:  apb_word = {16'h0000, lower_limit};
            OFS_IRQ_ST: apb_word = {30'h0, irq_status};
            OFS_IRQ_MK: apb_word = {30'h0, irq_mask};
            OFS_STATE:  apb_word = {20'h00000, configured, pclk_sync[1], alarm_aux,
                                    busy, 3'h0, channel};
            OFS_AUXRES: apb_word = {16'h0000, results[SLOT_AUX]};
            default:    apb_hit  = 1'b0;
        endcase
    end

    // one wait state so read data comes from a flip-flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !apb_hit;
            if (psel && penable && !pready) prdata <= apb_hit ? apb_word : 32'h0000_0000;
        end
    end

endmodule

/* pkg/asr_pkg.sv */
// constants shared by the monitor converter sequencer and its converter core
// assumes a single 40 MHz system clock; all times are in ns
package asr_pkg;

    // ****************************************
    // clock and conversion timing
    // ****************************************
    localparam int CLK_MHZ         = 40;
    localparam int CONV_TIME_NS    = 5200;
    localparam int CAL_TIME_NS     = 15600;
    localparam int CAL_STEPS       = 3;
    // least times round up to whole cycles
    localparam int CONV_CYCLES     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CAL_STEP_CYCLES = ((CAL_TIME_NS / CAL_STEPS) * CLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W      = 10;
    localparam int READ_LATENCY    = 4;

    // ****************************************
    // channel numbers and slots
    // ****************************************
    localparam logic [4:0] CH_TEMP    = 5'h00;
    localparam logic [4:0] CH_INT     = 5'h01;
    localparam logic [4:0] CH_AUX     = 5'h02;
    localparam logic [4:0] CH_DED     = 5'h03;
    localparam logic [4:0] CH_CAL     = 5'h08;
    localparam int         NUM_SLOTS  = 4;
    localparam int         SLOT_AUX   = 2;
    localparam logic [9:0] CAL_CODE   = 10'h200;
    localparam logic [3:0] ONCHIP_SEL = 4'h7;

    // ****************************************
    // configuration port addresses
    // ****************************************
    localparam logic [6:0] PA_SEQ     = 7'h48;
    localparam logic [6:0] PA_UPPER   = 7'h52;
    localparam logic [6:0] PA_LOWER   = 7'h56;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0]  SEQ_RST   = 4'h4;
    localparam logic [15:0] UPPER_RST = 16'hE000;
    localparam logic [15:0] LOWER_RST = 16'hCAAA;

    // ****************************************
    // apb byte offsets and interrupt bits
    // ****************************************
    localparam logic [11:0] OFS_SEQ    = 12'h000;
    localparam logic [11:0] OFS_UPPER  = 12'h004;
    localparam logic [11:0] OFS_LOWER  = 12'h008;
    localparam logic [11:0] OFS_IRQ_ST = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MK = 12'h010;
    localparam logic [11:0] OFS_STATE  = 12'h014;
    localparam logic [11:0] OFS_AUXRES = 12'h018;
    localparam int          IRQ_EOS    = 0;
    localparam int          IRQ_ALARM  = 1;

    typedef enum logic [2:0] {
        ST_CAL_START,
        ST_CAL_WAIT,
        ST_CH_START,
        ST_CH_WAIT,
        ST_EOS
    } asr_seq_state_t;

endpackage

/* rtl/asr_converter.sv */
// converter core: one timed conversion of a sampled 10-bit code
// assumes start is a one-cycle pulse issued only while busy is low
`timescale 1ns/1ps
module asr_converter
    import asr_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  start,
    input  wire logic [CONV_CNT_W-1:0] cycles,
    input  wire logic [9:0]            sample_code,
    output logic                       busy,
    output logic                       done,
    output logic [15:0]                result
);

    logic [CONV_CNT_W-1:0] count;
    logic [9:0]            held_code;

    // ****************************************
    // timing and sample hold
    // ****************************************
    // input is frozen at the busy rise so later changes wait for the next pass
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy      <= 1'b0;
            count     <= '0;
            held_code <= '0;
        end else if (start && !busy) begin
            busy      <= 1'b1;
            count     <= cycles - 10'h001;
            held_code <= sample_code;
        end else if (busy) begin
            if (count == '0) begin
                busy <= 1'b0;
            end
            count <= count - 10'h001;
        end
    end

    // done marks the last busy cycle so the sequencer stores on the busy-fall edge
    assign done   = busy && (count == '0);
    assign result = {held_code, 6'h00};

endmodule

/* verif/asr_monitor_props.sv */
// assertions on the monitor top-level ports
// assumes one clock domain and reset_n active low
`timescale 1ns/1ps
module asr_monitor_props
    import asr_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       busy,
    input wire logic       end_of_sequence,
    input wire logic [4:0] channel,
    input wire logic       alarm_aux,
    input wire logic       port_enable,
    input wire logic       port_data_ready,
    input wire logic       jtag_enable,
    input wire logic       jtag_data_ready
);
    // ****************
    // properties
    // ****************
    logic [9:0] busy_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // busy length; a long or short busy shows as a wrong count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) busy_len <= 10'h000;
        else busy_len <= busy ? busy_len + 10'h001 : 10'h000;
    end
    AST_CONV_LEN: assert property ($fell(busy) |-> busy_len == CONV_CYCLES)
        else $error("conversion length wrong");
    AST_CAL_AFTER_EOS: assert property (end_of_sequence |-> !busy ##1 busy)
        else $error("next pass did not start on time");
    AST_CHAN_ON_FALL: assert property ($changed(channel) |-> $fell(busy))
        else $error("channel changed outside conversion end");
    AST_ALARM_ON_FALL: assert property ($changed(alarm_aux) |-> $fell(busy))
        else $error("alarm changed outside conversion end");
    AST_ALARM_BEFORE_EOS: assert property ($rose(alarm_aux) |-> ##[1:215] end_of_sequence)
        else $error("no end of sequence after alarm");
    AST_READ_LAT: assert property (port_data_ready |-> $past(port_enable, 4))
        else $error("read data not four cycles after enable");
    AST_READY_PULSE: assert property (port_data_ready |=> !port_data_ready)
        else $error("data ready longer than one cycle");
    AST_APB_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    AST_DEBUG_ANSWER: assert property (jtag_enable |=> jtag_data_ready)
        else $error("debug port did not answer");
    cover property ($rose(alarm_aux));
    cover property (port_data_ready);
    cover property (end_of_sequence);
    cover property (jtag_data_ready);
endmodule

bind asr_monitor asr_monitor_props asr_monitor_props_inst (.clk, .reset_n, .psel, .penable,
    .pready, .busy, .end_of_sequence, .channel, .alarm_aux, .port_enable, .port_data_ready,
    .jtag_enable, .jtag_data_ready);

/* verif/asr_fabric_reader.sv */
// user logic that reads the newest result back at each end of sequence
// assumes the configuration port runs on clk
`timescale 1ns/1ps
module asr_fabric_reader (
    input wire logic         clk,
    input wire logic         reset_n,
    input wire logic         end_of_sequence,
    input wire logic [4:0]   channel,
    input wire logic [15:0]  port_read_data,
    input wire logic         port_data_ready,
    output logic             port_enable,
    output logic             port_write_enable,
    output logic [6:0]       port_address,
    output logic [15:0]      port_write_data,
    output logic [15:0]      last_word
);
    // ****************
    // read-back loop
    // ****************
    assign port_write_enable = 1'b0;
    assign port_write_data   = 16'h0000;
    // end of sequence fed back as enable, channel as address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_enable  <= 1'b0;
            port_address <= 7'h00;
        end else begin
            port_enable  <= end_of_sequence;
            port_address <= {2'b00, channel};
        end
    end
    // keep the word only when ready marks it valid
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) last_word <= 16'h0000;
        else if (port_data_ready) last_word <= port_read_data;
    end
endmodule

/* verif/adc_sequence_result_readout_tb_top.sv */
// self-checking bench for the monitor sequencer and its read ports
// assumes asr_fabric_reader drives the configuration port requests
`timescale 1ns/1ps
module adc_sequence_result_readout_tb_top
    import asr_pkg::*;
;
    // ****************
    // signals and instances
    // ****************
    logic        clk = 1'b0, reset_n = 1'b0, fabric_configured = 1'b0, port_clock_present = 1'b1;
    logic [9:0]  temp_code = 10'h1A0, int_supply_code = 10'h155, aux_supply_code = 10'h355;
    logic [9:0]  dedicated_input_positive = 10'h300, dedicated_input_negative = 10'h100;
    logic        jtag_enable = 1'b0, jtag_write_enable = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, port_enable, port_write_enable, port_data_ready, g;
    logic [6:0]  jtag_address = 7'h00, port_address;
    logic [15:0] jtag_write_data = 16'h0000, port_write_data, port_read_data, jtag_read_data;
    logic [15:0] last_word, jr;
    logic        jtag_data_ready, busy, end_of_sequence, alarm_aux, pready, pslverr, irq;
    logic [4:0]  channel;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    int          error_cnt = 0, n_compared = 0;
    // 40 MHz
    always #12.5 clk = ~clk;
    asr_monitor asr_monitor_inst (.clk, .reset_n, .fabric_configured, .port_clock_present,
        .temp_code, .int_supply_code, .aux_supply_code, .dedicated_input_positive,
        .dedicated_input_negative, .port_enable, .port_write_enable, .port_address,
        .port_write_data, .port_read_data, .port_data_ready, .jtag_enable, .jtag_write_enable,
        .jtag_address, .jtag_write_data, .jtag_read_data, .jtag_data_ready, .busy,
        .end_of_sequence, .channel, .alarm_aux, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq);
    asr_fabric_reader asr_fabric_reader_inst (.clk, .reset_n, .end_of_sequence, .channel,
        .port_read_data, .port_data_ready, .port_enable, .port_write_enable, .port_address,
        .port_write_data, .last_word);
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // bounded waits in wait_eos and apb end the run when exhausted; wait_rdy only records in g whether ready came within 8 cycles
    task automatic wait_eos();
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (end_of_sequence === 1'b1) break;
        end
        if (i == 3000) error_cnt++;
        if (i == 3000) tally_and_finish();
    endtask
    task automatic wait_rdy();
        g = 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (port_data_ready === 1'b1) g = 1'b1;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 8) error_cnt++;
        if (i == 8) tally_and_finish();
        r = prdata;
        g = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic jt(input logic w, input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        jtag_enable <= 1'b1;
        jtag_write_enable <= w;
        jtag_address <= a;
        jtag_write_data <= d;
        @(posedge clk);
        jtag_enable <= 1'b0;
        @(posedge clk);
        chk(32'(jtag_data_ready), 32'h1);
        jr = jtag_read_data;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic pre_config();
        wait_eos();
        jt(1'b0, 7'h00, 16'h0);
        chk(32'(jr), 32'h6800);
        jt(1'b0, 7'h02, 16'h0);
        chk(32'(jr), 32'hD540);
        jt(1'b0, 7'h03, 16'h0);
        chk(32'(jr), 32'h0);
        jt(1'b1, PA_SEQ, 16'h000C);
        wait_eos();
        wait_eos();
        jt(1'b0, 7'h03, 16'h0);
        chk(32'(jr), 32'h8000);
        jt(1'b1, PA_SEQ, 16'h0004);
    endtask
    task automatic config_read();
        fabric_configured <= 1'b1;
        wait_eos();
        wait_eos();
        chk(32'(channel), 32'(CH_AUX));
        wait_rdy();
        chk({15'h0, g, last_word}, 32'h1D540);
        aux_supply_code <= 10'h3BB;
        wait_eos();
        chk(32'(alarm_aux), 32'h1);
        wait_rdy();
        chk({15'h0, g, last_word}, 32'h1EEC0);
    endtask
    task automatic no_port_clock();
        port_clock_present <= 1'b0;
        aux_supply_code <= 10'h355;
        wait_eos();
        wait_rdy();
        chk({15'h0, g, last_word}, 32'hEEC0);
        chk(32'(alarm_aux), 32'h0);
        port_clock_present <= 1'b1;
    endtask
    task automatic apb_irq();
        apb(1'b0, OFS_UPPER, 32'h0);
        chk(r, 32'h0000E000);
        apb(1'b1, OFS_IRQ_MK, 32'h2);
        @(posedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_IRQ_ST, 32'h3);
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk(r & 32'h2, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({r[30:0], g}, 32'h1);
    endtask
    // main sequence, reset held three cycles
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        pre_config();
        config_read();
        no_port_clock();
        apb_irq();
        tally_and_finish();
    end
endmodule
